/* logic/plor_consts.svh */
// Purpose: offsets, field positions, codes and reset values of the port link override bank
// Assumes: register indices are word indices; byte address is index times four
// Notes: included by the bank and its field multiplexer
`ifndef PLOR_CONSTS_SVH
`define PLOR_CONSTS_SVH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define PLOR_IDX_P4 16'hF411
`define PLOR_IDX_P3 16'hF412
`define PLOR_IDX_CFG 16'hF414
`define PLOR_IDX_STAT 16'hF415
`define PLOR_ADDR_P4 {`PLOR_IDX_P4, 2'b00}
`define PLOR_ADDR_P3 {`PLOR_IDX_P3, 2'b00}
`define PLOR_ADDR_CFG {`PLOR_IDX_CFG, 2'b00}
`define PLOR_ADDR_STAT {`PLOR_IDX_STAT, 2'b00}

// ----------------------------------------------------------------
// reset values and port 4 write mask
// ----------------------------------------------------------------
`define PLOR_RST_P4 16'h1804
`define PLOR_RST_P3 16'h1803
`define PLOR_RST_CFG 1'b1
`define PLOR_P4_WMASK 16'h7FFF

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define PLOR_F_SRC 15
`define PLOR_F_LINK_HI 14
`define PLOR_F_LINK_LO 13
`define PLOR_F_SPEED_HI 12
`define PLOR_F_SPEED_LO 11
`define PLOR_F_DUP_HI 10
`define PLOR_F_DUP_LO 9
`define PLOR_F_TXP_HI 8
`define PLOR_F_TXP_LO 7
`define PLOR_F_RXP_HI 6
`define PLOR_F_RXP_LO 5
`define PLOR_F_ADDR_HI 4
`define PLOR_F_ADDR_LO 0

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define PLOR_LINK_UP 2'b01
`define PLOR_LINK_DOWN 2'b10
`define PLOR_SPEED_AUTO 2'b11
`define PLOR_DUP_FULL 2'b01
`define PLOR_DUP_HALF 2'b11
`define PLOR_PAUSE_INGRESS 2'b01
`define PLOR_PAUSE_EGRESS 2'b11
`define PLOR_PAUSE_EFF_INGRESS 2'b01
`define PLOR_PAUSE_EFF_EGRESS 2'b10

// ----------------------------------------------------------------
// link info word: link, speed, duplex, tx pause, rx pause
// ----------------------------------------------------------------
`define PLOR_INFO_IDLE 8'h00

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define PLOR_RESP_OKAY 2'b00
`define PLOR_RESP_SLVERR 2'b10

`endif

/* logic/plor_field_mux.sv */
// Purpose: turn one control word and the automatic values into effective link parameters
// Assumes: control word layout as in plor_consts.svh
// Notes: combinational; the bank registers the result
`timescale 1ns/10ps
`default_nettype none
`include "plor_consts.svh"

module plor_field_mux
    import plor_pkg::*;
(
    input wire logic [15:0] ctrl,
    plor_link_if.sink auto_in,
    plor_link_if.src eff_out
);

    wire logic [1:0] link_code;
    wire logic [1:0] speed_code;
    wire logic [1:0] dup_code;
    wire logic [1:0] txp_code;
    wire logic [1:0] rxp_code;

    assign link_code = ctrl[`PLOR_F_LINK_HI:`PLOR_F_LINK_LO];
    assign speed_code = ctrl[`PLOR_F_SPEED_HI:`PLOR_F_SPEED_LO];
    assign dup_code = ctrl[`PLOR_F_DUP_HI:`PLOR_F_DUP_LO];
    assign txp_code = ctrl[`PLOR_F_TXP_HI:`PLOR_F_TXP_LO];
    assign rxp_code = ctrl[`PLOR_F_RXP_HI:`PLOR_F_RXP_LO];

    // reserved code 11 falls back to the automatic value
    assign eff_out.link = (link_code == `PLOR_LINK_UP) ? 1'b1 :
                          (link_code == `PLOR_LINK_DOWN) ? 1'b0 : auto_in.link;

    // code 10 stands for 1 Gbps, or the top rate the serial link runs
    assign eff_out.speed = (speed_code == `PLOR_SPEED_AUTO) ? auto_in.speed
                                                             : speed_code;

    assign eff_out.duplex = (dup_code == `PLOR_DUP_FULL) ? 1'b1 :
                            (dup_code == `PLOR_DUP_HALF) ? 1'b0 : auto_in.duplex;

    assign eff_out.tx_pause = (txp_code == `PLOR_PAUSE_INGRESS) ? `PLOR_PAUSE_EFF_INGRESS :
                              (txp_code == `PLOR_PAUSE_EGRESS) ? `PLOR_PAUSE_EFF_EGRESS :
                              auto_in.tx_pause;

    assign eff_out.rx_pause = (rxp_code == `PLOR_PAUSE_INGRESS) ? `PLOR_PAUSE_EFF_INGRESS :
                              (rxp_code == `PLOR_PAUSE_EGRESS) ? `PLOR_PAUSE_EFF_EGRESS :
                              auto_in.rx_pause;

endmodule : plor_field_mux

`default_nettype wire

/* logic/plor_link_if.sv */
// Purpose: one port's link parameters between bank and field multiplexer
// Assumes: single clock, purely combinational carrier
// Notes: src drives, sink reads
`timescale 1ns/10ps
`default_nettype none

interface plor_link_if;
    logic link;
    logic [1:0] speed;
    logic duplex;
    logic [1:0] tx_pause;
    logic [1:0] rx_pause;

    modport src
    (
        output link,
        output speed,
        output duplex,
        output tx_pause,
        output rx_pause
    );

    modport sink
    (
        input link,
        input speed,
        input duplex,
        input tx_pause,
        input rx_pause
    );
endinterface : plor_link_if

`default_nettype wire

/* logic/plor_pkg.sv */
// Purpose: types of the port link override bank
// Assumes: constants live in plor_consts.svh
// Notes: info word packs one port's effective link parameters
package plor_pkg;

    typedef logic [1:0] plor_speed_t;

    typedef struct packed {
        logic link;
        plor_speed_t speed;
        logic duplex;
        logic [1:0] tx_pause;
        logic [1:0] rx_pause;
    } plor_info_t;

endpackage : plor_pkg

/* logic/plor_port_link_regs.sv */
// Purpose: link override registers of ports 3 and 4 behind an AXI4-Lite slave
// Assumes: automatic sources are synchronous to aclk
// Notes: one write and one read in flight; effective values registered
`timescale 1ns/10ps
`default_nettype none
`include "plor_consts.svh"

module plor_port_link_regs
    import plor_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] p3_poll_info,
    input wire logic [7:0] p3_xcvr_info,
    input wire logic [7:0] p4_sgmii_info,
    output logic [7:0] p3_eff_info,
    output logic [7:0] p4_eff_info,
    output logic [4:0] p3_phy_addr,
    output logic [4:0] p4_phy_addr,
    output logic poll_enable
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0] port3_link_override;
    logic [15:0] port4_link_override;
    logic poll_engine_config;

    // ----------------------------------------------------------------
    // write channel state
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr_q;
    logic [15:0] w_data_q;
    logic [1:0] w_strb_q;

    wire logic aw_take;
    wire logic w_take;
    wire logic have_aw;
    wire logic have_w;
    wire logic do_write;
    wire logic [31:0] wr_addr;
    wire logic [15:0] wr_data;
    wire logic [1:0] wr_strb;
    wire logic wr_hi_zero;
    wire logic wr_hit_p3;
    wire logic wr_hit_p4;
    wire logic wr_hit_cfg;
    wire logic wr_ok;
    wire logic [15:0] next_port3;
    wire logic [15:0] next_port4;
    wire logic next_cfg;

    // lanes 2 and 3 carry nothing: registers are 16 bits
    function automatic logic [15:0] plor_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                               input logic [1:0] strb);
        plor_merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : plor_merge

    // address and data may arrive in either order; hold whichever comes first
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign have_aw = aw_held | aw_take;
    assign have_w = w_held | w_take;
    assign do_write = have_aw & have_w;

    assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_held ? w_data_q : s_axi_wdata[15:0];
    assign wr_strb = w_held ? w_strb_q : s_axi_wstrb[1:0];

    assign wr_hi_zero = (wr_addr[31:18] == 14'h0000);
    assign wr_hit_p3 = wr_hi_zero & (wr_addr[17:0] == `PLOR_ADDR_P3);
    assign wr_hit_p4 = wr_hi_zero & (wr_addr[17:0] == `PLOR_ADDR_P4);
    assign wr_hit_cfg = wr_hi_zero & (wr_addr[17:0] == `PLOR_ADDR_CFG);
    assign wr_ok = wr_hit_p3 | wr_hit_p4 | wr_hit_cfg;

    assign next_port3 = plor_merge(port3_link_override, wr_data, wr_strb);
    // bit 15 of port 4 is reserved: never stored, reads zero
    assign next_port4 = plor_merge(port4_link_override, wr_data, wr_strb)
                        & `PLOR_P4_WMASK;
    assign next_cfg = wr_strb[0] ? wr_data[0] : poll_engine_config;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b0;
        end
        else if (aw_take)
        begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data_q <= 16'h0000;
            w_strb_q <= 2'b00;
            s_axi_wready <= 1'b1;
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (w_take)
        begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PLOR_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `PLOR_RESP_OKAY : `PLOR_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port3_link_override <= `PLOR_RST_P3;
            port4_link_override <= `PLOR_RST_P4;
            poll_engine_config <= `PLOR_RST_CFG;
        end
        else if (do_write)
        begin
            if (wr_hit_p3)
            begin
                port3_link_override <= next_port3;
            end
            if (wr_hit_p4)
            begin
                port4_link_override <= next_port4;
            end
            if (wr_hit_cfg)
            begin
                poll_engine_config <= next_cfg;
            end
        end
    end

    // ----------------------------------------------------------------
    // automatic sources
    // ----------------------------------------------------------------
    wire logic [7:0] p3_poll_gated;
    wire logic [7:0] p3_auto;

    // polling off: no polled value is trusted; unforced fields read idle unless bit 15 picks the transceiver
    assign p3_poll_gated = poll_engine_config ? p3_poll_info : `PLOR_INFO_IDLE;
    assign p3_auto = port3_link_override[`PLOR_F_SRC] ? p3_xcvr_info
                                                        : p3_poll_gated;

    // ----------------------------------------------------------------
    // per-port field multiplexers
    // ----------------------------------------------------------------
    logic [15:0] ctrl_word [2];
    logic [7:0] auto_info [2];
    logic [7:0] eff_info [2];

    assign ctrl_word[0] = port3_link_override;
    assign ctrl_word[1] = port4_link_override;
    assign auto_info[0] = p3_auto;
    assign auto_info[1] = p4_sgmii_info;

    for (genvar gi = 0; gi < 2; gi++)
    begin : g_port
        plor_link_if auto_if();
        plor_link_if eff_if();
        plor_info_t auto_s;
        plor_info_t eff_s;

        assign auto_s = plor_info_t'(auto_info[gi]);
        assign auto_if.link = auto_s.link;
        assign auto_if.speed = auto_s.speed;
        assign auto_if.duplex = auto_s.duplex;
        assign auto_if.tx_pause = auto_s.tx_pause;
        assign auto_if.rx_pause = auto_s.rx_pause;

        plor_field_mux u_mux
        (
            .ctrl(ctrl_word[gi]),
            .auto_in(auto_if.sink),
            .eff_out(eff_if.src)
        );

        assign eff_s.link = eff_if.link;
        assign eff_s.speed = eff_if.speed;
        assign eff_s.duplex = eff_if.duplex;
        assign eff_s.tx_pause = eff_if.tx_pause;
        assign eff_s.rx_pause = eff_if.rx_pause;
        assign eff_info[gi] = eff_s;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // effective info is one cycle behind the register write; phy addresses and poll enable follow the registers directly
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            p3_eff_info <= `PLOR_INFO_IDLE;
            p4_eff_info <= `PLOR_INFO_IDLE;
        end
        else
        begin
            p3_eff_info <= eff_info[0];
            p4_eff_info <= eff_info[1];
        end
    end

    assign p3_phy_addr = port3_link_override[`PLOR_F_ADDR_HI:`PLOR_F_ADDR_LO];
    assign p4_phy_addr = port4_link_override[`PLOR_F_ADDR_HI:`PLOR_F_ADDR_LO];
    assign poll_enable = poll_engine_config;

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    wire logic ar_take;
    wire logic rd_hi_zero;
    wire logic rd_hit_p3;
    wire logic rd_hit_p4;
    wire logic rd_hit_cfg;
    wire logic rd_hit_stat;
    wire logic rd_ok;
    wire logic [31:0] rd_word;

    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rd_hi_zero = (s_axi_araddr[31:18] == 14'h0000);
    assign rd_hit_p3 = rd_hi_zero & (s_axi_araddr[17:0] == `PLOR_ADDR_P3);
    assign rd_hit_p4 = rd_hi_zero & (s_axi_araddr[17:0] == `PLOR_ADDR_P4);
    assign rd_hit_cfg = rd_hi_zero & (s_axi_araddr[17:0] == `PLOR_ADDR_CFG);
    assign rd_hit_stat = rd_hi_zero & (s_axi_araddr[17:0] == `PLOR_ADDR_STAT);
    assign rd_ok = rd_hit_p3 | rd_hit_p4 | rd_hit_cfg | rd_hit_stat;

    // status shows the parameters the port is really running with
    assign rd_word = rd_hit_p3 ? {16'h0000, port3_link_override} :
                     rd_hit_p4 ? {16'h0000, port4_link_override} :
                     rd_hit_cfg ? {31'h0000_0000, poll_engine_config} :
                     rd_hit_stat ? {16'h0000, p4_eff_info, p3_eff_info} :
                     32'h0000_0000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PLOR_RESP_OKAY;
            s_axi_arready <= 1'b1;
        end
        else if (ar_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `PLOR_RESP_OKAY : `PLOR_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : plor_port_link_regs

`default_nettype wire

/* tb/plor_assertions.sv */
// Purpose: bus and link output checks of the port link override bank
// Assumes: write address and data offered together by the master
// Notes: bound to plor_port_link_regs
`timescale 1ns/10ps
`default_nettype none
`include "plor_consts.svh"

module plor_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] p4_eff_info,
    input wire logic [4:0] p3_phy_addr,
    input wire logic [4:0] p4_phy_addr,
    input wire logic poll_enable
);
    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire wr_p4 = wr_hs && (s_axi_awaddr == 32'(`PLOR_ADDR_P4));

    property p_b_after_wr;
        wr_hs |=> s_axi_bvalid;
    endproperty
    a_b_after_wr: assert property (p_b_after_wr) else $error("write not answered");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_after_ar;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_r_after_ar: assert property (p_r_after_ar) else $error("read not answered");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_busy;
        s_axi_bvalid || s_axi_rvalid |-> !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready);
    endproperty
    a_busy: assert property (p_busy) else $error("ready while answer pending");
    property p_unmapped;
        wr_hs && s_axi_awaddr[31:18] != 14'h0000 |=> s_axi_bresp == 2'b10;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write accepted");
    property p_link_up;
        wr_p4 && s_axi_wstrb[1] && s_axi_wdata[14:13] == 2'b01 |=> ##1 p4_eff_info[7];
    endproperty
    a_link_up: assert property (p_link_up) else $error("forced link up missing");
    property p_speed;
        wr_p4 && s_axi_wstrb[1] && s_axi_wdata[12:11] != 2'b11
            |=> ##1 p4_eff_info[6:5] == $past(s_axi_wdata[12:11], 2);
    endproperty
    a_speed: assert property (p_speed) else $error("forced speed wrong");
    property p_addr;
        wr_p4 && s_axi_wstrb[0] |=> p4_phy_addr == $past(s_axi_wdata[4:0]);
    endproperty
    a_addr: assert property (p_addr) else $error("transceiver address wrong");
    property p_rst_vals;
        $rose(aresetn) |-> p4_phy_addr == 5'h04 && p3_phy_addr == 5'h03 && poll_enable;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
    c_wr_p4: cover property (wr_p4);
    c_rd_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'b10);
    c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : plor_checker

bind plor_port_link_regs plor_checker u_plor_checker (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .p4_eff_info, .p3_phy_addr, .p4_phy_addr,
    .poll_enable);

`default_nettype wire

/* tb/plor_tb.sv */
// Purpose: self-checking bench of the port link override bank
// Assumes: one AXI4-Lite master, address and data offered together
// Notes: expected link values rebuilt from the field codes
`timescale 1ns/10ps
`default_nettype none
`include "plor_consts.svh"

module testbench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, xv_sel, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, poll_enable;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] p3_poll_info, p3_xcvr_info, p4_sgmii_info, p3_eff_info, p4_eff_info;
    logic [4:0] p3_phy_addr, p4_phy_addr;
    int err_count, cmp_count;

    plor_port_link_regs u_plor_port_link_regs (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .p3_poll_info, .p3_xcvr_info,
        .p4_sgmii_info, .p3_eff_info, .p4_eff_info, .p3_phy_addr, .p4_phy_addr, .poll_enable);
    plor_xcvr_model u_plor_xcvr_model (.aclk, .aresetn, .sel(xv_sel), .p3_poll_info,
        .p3_xcvr_info, .p4_sgmii_info);

    always #25 aclk = ~aclk;

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask : rd

    function automatic logic [7:0] exp_eff(input logic [15:0] c, input logic [7:0] a);
        logic [7:0] e;
        e = a;
        if (c[14:13] == 2'b01) e[7] = 1'b1;
        if (c[14:13] == 2'b10) e[7] = 1'b0;
        if (c[12:11] != 2'b11) e[6:5] = c[12:11];
        if (c[10:9] == 2'b01) e[4] = 1'b1;
        if (c[10:9] == 2'b11) e[4] = 1'b0;
        if (c[8:7] == 2'b01) e[3:2] = 2'b01;
        if (c[8:7] == 2'b11) e[3:2] = 2'b10;
        if (c[6:5] == 2'b01) e[1:0] = 2'b01;
        if (c[6:5] == 2'b11) e[1:0] = 2'b10;
        return e;
    endfunction : exp_eff

    task test_done;
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(`PLOR_ADDR_P4, 32'h0000_1804, 2'b00);
        rd(`PLOR_ADDR_P3, 32'h0000_1803, 2'b00);
        rd(`PLOR_ADDR_CFG, 32'h0000_0001, 2'b00);
        chk(p4_phy_addr, 5'h04);
        chk(p4_eff_info, exp_eff(16'h1804, p4_sgmii_info));
    endtask : t_reset

    // every code of every field, reserved bit 15 always set
    task automatic t_p4_codes;
        logic [15:0] c;
        for (int i = 0; i < 8; i++)
        begin
            xv_sel <= i[2];
            c = {1'b1, {5{i[1:0]}}, 5'(i + 4)};
            wr(`PLOR_ADDR_P4, {16'h0000, c}, 2'b00);
            repeat (2) @(posedge aclk);
            chk(p4_eff_info, exp_eff(c, p4_sgmii_info));
            chk(p4_phy_addr, 5'(i + 4));
            rd(`PLOR_ADDR_P4, {17'h0_0000, c[14:0]}, 2'b00);
        end
    endtask : t_p4_codes

    // reserved or auto codes everywhere, so the source and polling alone decide
    task automatic t_p3_src;
        logic [15:0] c;
        logic [7:0] e;
        for (int k = 0; k < 4; k++)
        begin
            c = {k[0], 2'b11, 2'b11, 2'b10, 2'b10, 2'b10, 5'h1f};
            wr(`PLOR_ADDR_CFG, {31'h0000_0000, k[1]}, 2'b00);
            wr(`PLOR_ADDR_P3, {16'h0000, c}, 2'b00);
            repeat (2) @(posedge aclk);
            e = k[0] ? p3_xcvr_info : (k[1] ? p3_poll_info : 8'h00);
            chk(p3_eff_info, e);
            chk(poll_enable, k[1]);
            chk(p3_phy_addr, 5'h1f);
        end
        wr(`PLOR_ADDR_CFG, 32'h0000_0001, 2'b00);
    endtask : t_p3_src

    task automatic t_bus_err;
        wr(`PLOR_ADDR_P4, 32'h0000_2a65, 2'b00);
        wr(32'h0007_d044, 32'h0000_ffff, 2'b10);
        wr(`PLOR_ADDR_STAT, 32'h0000_ffff, 2'b10);
        rd(32'h0000_0100, 32'h0000_0000, 2'b10);
        rd(`PLOR_ADDR_STAT, {16'h0000, exp_eff(16'h2a65, p4_sgmii_info), p3_xcvr_info},
           2'b00);
        rd(`PLOR_ADDR_P4, 32'h0000_2a65, 2'b00);
    endtask : t_bus_err

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'h0;
        xv_sel = 1'b0;
        err_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_p4_codes;
        t_p3_src;
        t_bus_err;
        test_done;
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_count++;
        test_done;
    end
endmodule : testbench

`default_nettype wire

/* tb/plor_xcvr_model.sv */
// Purpose: status seen from the polled, integrated and serial transceivers
// Assumes: values already in the switch clock domain
// Notes: sel flips between two link pictures
`timescale 1ns/10ps
`default_nettype none

module plor_xcvr_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sel,
    output logic [7:0] p3_poll_info,
    output logic [7:0] p3_xcvr_info,
    output logic [7:0] p4_sgmii_info
);
    // status refreshes one edge late, like a poll round landing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            p3_poll_info <= 8'h00;
            p3_xcvr_info <= 8'h00;
            p4_sgmii_info <= 8'h00;
        end
        else
        begin
            p3_poll_info <= sel ? 8'h2a : 8'hd5;
            p3_xcvr_info <= sel ? 8'hc6 : 8'h39;
            p4_sgmii_info <= sel ? 8'h39 : 8'hc6;
        end
    end
endmodule : plor_xcvr_model

`default_nettype wire
